// ===== cmbd_map.vh
// Constants for the core memory bit data path
`ifndef CMBD_MAP_VH
`define CMBD_MAP_VH
`define CMBD_ADDR_LSB 21
`define CMBD_ADDR_W 15
`define CMBD_XDRV_LSB 0
`define CMBD_XSW_LSB 4
`define CMBD_YDRV_LSB 8
`define CMBD_YSW_LSB 11
`define CMBD_N_SW 16
`define CMBD_N_YDRV 8
`define CMBD_N_X 256
`define CMBD_N_Y 128
`define CMBD_CYCLE_NS 1200
`define CMBD_READ_NS 350
`define CMBD_STROBE_START_NS 200
`define CMBD_STROBE_NS 100
`define CMBD_WRITE_NS 400
`define CMBD_CLK_NS 50
`endif

// ===== cmbd_decoder.v
// Active-low one-of-N decoder with enable
module cmbd_decoder #(
    parameter IN_W = 4,
    parameter OUT_N = 16
) (
    input wire [IN_W-1:0] sel,
    input wire enable,
    output wire [OUT_N-1:0] out_n
);
    genvar i;
    generate
        for (i = 0; i < OUT_N; i = i + 1) begin : g_dec
            localparam [IN_W-1:0] CODE = i;
            assign out_n[i] = ~(enable && (sel == CODE));
        end
    endgenerate
endmodule // cmbd_decoder

// ===== cmbd_bit_slice.v
// One data bit: sense amps, data latch, inhibit drivers, bus driver
module cmbd_bit_slice (
    input wire mclk,
    input wire rst_n,
    input wire data_latch_clear_n,
    input wire data_latch_load_clock,
    input wire sense_strobe_even_half,
    input wire sense_strobe_odd_half,
    input wire inhibit_select_even_half,
    input wire inhibit_select_odd_half,
    input wire bus_drive_enable_n,
    input wire sense_even_pulse,
    input wire sense_odd_pulse,
    input wire bus_data_in_n,
    output wire sense_even_out_n,
    output wire sense_odd_out_n,
    output wire inhibit_even_on,
    output wire inhibit_odd_on,
    output wire bus_data_out,
    output wire bus_data_oe_n,
    output wire memory_data_latch
);
    reg latch_bit;
    wire set_n;
    wire load_d;
    // Sense amp low only under strobe with pulse above threshold
    assign sense_even_out_n = ~(sense_strobe_even_half & sense_even_pulse); // see RULE10
    assign sense_odd_out_n = ~(sense_strobe_odd_half & sense_odd_pulse); // see RULE10
    assign set_n = sense_even_out_n & sense_odd_out_n;
    // Line receiver inverts active-low bus bit
    assign load_d = ~bus_data_in_n; // see RULE17
    // Clear at cycle start; set by sense wins over clock load
    always @(posedge mclk) begin
        if (!rst_n || !data_latch_clear_n) begin
            latch_bit <= 1'b0; // see RULE11
        end else if (!set_n) begin
            latch_bit <= 1'b1; // see RULE12
        end else if (data_latch_load_clock) begin
            latch_bit <= load_d; // see RULE18
        end
    end
    assign memory_data_latch = latch_bit;
    // Inhibit only for a zero bit on the selected half
    assign inhibit_even_on = inhibit_select_even_half & ~latch_bit; // see RULE15 RULE16
    assign inhibit_odd_on = inhibit_select_odd_half & ~latch_bit; // see RULE15 RULE16
    // Open-drain bus line: pull low for a one
    assign bus_data_out = 1'b0;
    assign bus_data_oe_n = ~(~bus_drive_enable_n & latch_bit); // see RULE13
endmodule // cmbd_bit_slice

// ===== cmbd_datapath.v
// Core memory bit data path: timing, address latch, X/Y selection, one bit slice
// Functional notes
// RULE1: Each switch or driver enabled by one decoder output, selected when low.
// RULE2: Sixteen Y switch pairs and eight driver pairs select one of 128 Y lines.
// RULE3: X selection covers 256 switch/driver combinations, one X line per cycle.
// RULE4: Write driver and write switch conduct only during write timing.
// RULE5: Read switch and read driver conduct under read timing, opposite direction.
// RULE6: Two sense amps and inhibit drivers per bit; one pair active per reference.
// RULE7: Address bit 34 zero (or swapped bit in 4-way) selects strobe even, inhibit even.
// RULE8: Bit 34 or swapped bit one selects strobe odd with inhibit odd.
// RULE9: Read currents oppose write currents; ones forced to zero.
// RULE10: Sense output low only when strobed and pulse exceeds threshold.
// RULE11: Latch clear asserted at start of every memory cycle.
// RULE12: Low sense output sets the latch bit.
// RULE13: Enabled bus driver pulls data line low for a set bit.
// RULE14: Every read is immediately followed by a restore write of latched data.
// RULE15: Set latch bit keeps selected inhibit driver off, writing a one.
// RULE16: Cleared latch bit turns selected inhibit driver on, keeping zero.
// RULE17: Requester presents bus data; receiver inverts active-low bit into latch.
// RULE18: Latch clock pulses during a write, capturing the inverted bus bit.
// RULE19: Word-select address bits 21 to 35 are held in address latches.
// RULE20: Three bits pick a Y driver; groups of four pick X drivers and switches.
// RULE21: Sense strobe after read current starts, ends before write timing.
`include "cmbd_map.vh"
module cmbd_datapath #(
    parameter CYCLE_NS = `CMBD_CYCLE_NS,
    parameter CLK_NS = `CMBD_CLK_NS,
    parameter READ_NS = `CMBD_READ_NS,
    parameter STROBE_START_NS = `CMBD_STROBE_START_NS,
    parameter STROBE_NS = `CMBD_STROBE_NS,
    parameter WRITE_NS = `CMBD_WRITE_NS
) (
    input wire mclk,
    input wire rst_n,
    input wire cycle_start,
    input wire write_request,
    input wire [20:0] bus_address_lo,
    input wire [14:0] word_address,
    input wire interleave_four_way,
    input wire [1:0] memory_size,
    input wire sense_even_pulse,
    input wire sense_odd_pulse,
    input wire bus_data_in_n,
    output wire busy,
    output reg cycle_done,
    output wire [`CMBD_N_SW-1:0] x_driver_sel_n,
    output wire [`CMBD_N_SW-1:0] x_switch_sel_n,
    output wire [`CMBD_N_YDRV-1:0] y_driver_sel_n,
    output wire [`CMBD_N_SW-1:0] y_switch_sel_n,
    output wire read_timing,
    output wire write_timing,
    output wire sense_strobe_even_half,
    output wire sense_strobe_odd_half,
    output wire inhibit_select_even_half,
    output wire inhibit_select_odd_half,
    output wire inhibit_even_on,
    output wire inhibit_odd_on,
    output wire data_latch_clear_n,
    output wire data_latch_load_clock,
    output wire bus_drive_enable_n,
    output wire bus_data_out,
    output wire bus_data_oe_n,
    output wire memory_data_latch
);
    // Cycle counts derived from times
    localparam integer CYC_TOTAL = (CYCLE_NS + CLK_NS - 1) / CLK_NS;
    localparam integer CYC_READ = (READ_NS + CLK_NS - 1) / CLK_NS;
    localparam integer CYC_STB0 = (STROBE_START_NS + CLK_NS - 1) / CLK_NS;
    localparam integer CYC_STB_RAW = STROBE_NS / CLK_NS;
    localparam integer CYC_STB = (CYC_STB_RAW < 1) ? 1 : CYC_STB_RAW;
    localparam integer CYC_WRITE = (WRITE_NS + CLK_NS - 1) / CLK_NS;
    localparam integer CNT_W = 6;

    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_READ = 4'h2;
    localparam [3:0] ST_WRITE = 4'h4;
    localparam [3:0] ST_RECOVER = 4'h8;

    reg [3:0] state;
    reg [3:0] next_state;
    reg [CNT_W-1:0] count;
    reg [CNT_W-1:0] phase;
    reg [`CMBD_ADDR_W-1:0] addr_latch;
    reg half_odd;
    reg is_write;
    reg first_cycle;
    wire swap_bit;
    wire strobe_window;
    wire in_read;
    wire in_write;

    function [CNT_W-1:0] cyc;
        input integer n;
        begin
            cyc = n[CNT_W-1:0];
        end
    endfunction

    // Bit swapped with 34 depends on memory size
    assign swap_bit = (memory_size == 2'h0) ? bus_address_lo[19] :
                      (memory_size == 2'h1) ? bus_address_lo[18] : bus_address_lo[17];

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (cycle_start) begin
                    next_state = ST_READ;
                end
            end
            ST_READ: begin
                if (count == cyc(CYC_READ - 1)) begin
                    next_state = ST_WRITE; // see RULE14
                end
            end
            ST_WRITE: begin
                if (count == cyc(CYC_WRITE - 1)) begin
                    next_state = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                if (phase >= cyc(CYC_TOTAL - 1)) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            count <= 6'h00;
            phase <= 6'h00;
            addr_latch <= 15'h0000;
            half_odd <= 1'b0;
            is_write <= 1'b0;
            first_cycle <= 1'b0;
            cycle_done <= 1'b0;
        end else begin
            state <= next_state;
            cycle_done <= (state == ST_RECOVER) && (next_state == ST_IDLE);
            first_cycle <= (state == ST_IDLE) && cycle_start;
            if (next_state != state) begin
                count <= 6'h00;
            end else begin
                count <= count + 6'h01;
            end
            if (state == ST_IDLE) begin
                phase <= 6'h00;
            end else begin
                phase <= phase + 6'h01;
            end
            if (state == ST_IDLE && cycle_start) begin
                addr_latch <= word_address; // see RULE19
                half_odd <= interleave_four_way ? swap_bit : word_address[13]; // see RULE7 RULE8
                is_write <= write_request;
            end
        end
    end

    assign busy = (state != ST_IDLE);
    assign in_read = (state == ST_READ);
    assign in_write = (state == ST_WRITE);
    assign read_timing = in_read; // see RULE5 RULE9
    assign write_timing = in_write; // see RULE4
    // Strobe window lies inside read timing, ends before write
    assign strobe_window = in_read && !is_write && (count >= cyc(CYC_STB0)) &&
                           (count < cyc(CYC_STB0 + CYC_STB)) &&
                           (count < cyc(CYC_READ)); // see RULE21
    assign sense_strobe_even_half = strobe_window && !half_odd; // see RULE6 RULE7
    assign sense_strobe_odd_half = strobe_window && half_odd; // see RULE8
    assign inhibit_select_even_half = in_write && !half_odd; // see RULE7
    assign inhibit_select_odd_half = in_write && half_odd; // see RULE8
    assign data_latch_clear_n = ~first_cycle; // see RULE11
    // Load on last read cycle so a written one never sees inhibit current
    assign data_latch_load_clock = in_read && is_write && (count == cyc(CYC_READ - 1)); // see RULE18
    assign bus_drive_enable_n = ~(in_write && !is_write);

    // Decoders enabled only in read or write timing
    cmbd_decoder #(.IN_W(4), .OUT_N(`CMBD_N_SW)) u_xdrv (
        .sel(addr_latch[`CMBD_XDRV_LSB+3:`CMBD_XDRV_LSB]),
        .enable(in_read | in_write),
        .out_n(x_driver_sel_n)
    ); // see RULE1 RULE3 RULE20
    cmbd_decoder #(.IN_W(4), .OUT_N(`CMBD_N_SW)) u_xsw (
        .sel(addr_latch[`CMBD_XSW_LSB+3:`CMBD_XSW_LSB]),
        .enable(in_read | in_write),
        .out_n(x_switch_sel_n)
    ); // see RULE3
    cmbd_decoder #(.IN_W(3), .OUT_N(`CMBD_N_YDRV)) u_ydrv (
        .sel(addr_latch[`CMBD_YDRV_LSB+2:`CMBD_YDRV_LSB]),
        .enable(in_read | in_write),
        .out_n(y_driver_sel_n)
    ); // see RULE2 RULE20
    cmbd_decoder #(.IN_W(4), .OUT_N(`CMBD_N_SW)) u_ysw (
        .sel(addr_latch[`CMBD_YSW_LSB+3:`CMBD_YSW_LSB]),
        .enable(in_read | in_write),
        .out_n(y_switch_sel_n)
    ); // see RULE2

    cmbd_bit_slice u_bit (
        .mclk(mclk),
        .rst_n(rst_n),
        .data_latch_clear_n(data_latch_clear_n),
        .data_latch_load_clock(data_latch_load_clock),
        .sense_strobe_even_half(sense_strobe_even_half),
        .sense_strobe_odd_half(sense_strobe_odd_half),
        .inhibit_select_even_half(inhibit_select_even_half),
        .inhibit_select_odd_half(inhibit_select_odd_half),
        .bus_drive_enable_n(bus_drive_enable_n),
        .sense_even_pulse(sense_even_pulse),
        .sense_odd_pulse(sense_odd_pulse),
        .bus_data_in_n(bus_data_in_n),
        .sense_even_out_n(),
        .sense_odd_out_n(),
        .inhibit_even_on(inhibit_even_on),
        .inhibit_odd_on(inhibit_odd_on),
        .bus_data_out(bus_data_out),
        .bus_data_oe_n(bus_data_oe_n),
        .memory_data_latch(memory_data_latch)
    );
endmodule // cmbd_datapath

// ===== cmbd_datapath_properties.sv
// Concurrent checks for the core memory bit data path
module cmbd_datapath_properties (
    input wire mclk,
    input wire rst_n,
    input wire cycle_start,
    input wire busy,
    input wire [14:0] word_address,
    input wire interleave_four_way,
    input wire sense_even_pulse,
    input wire [15:0] x_driver_sel_n,
    input wire [7:0] y_driver_sel_n,
    input wire read_timing,
    input wire write_timing,
    input wire sense_strobe_even_half,
    input wire sense_strobe_odd_half,
    input wire inhibit_select_even_half,
    input wire inhibit_even_on,
    input wire data_latch_clear_n,
    input wire bus_drive_enable_n,
    input wire bus_data_oe_n,
    input wire memory_data_latch
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_read;
        read_timing [*7];
    endsequence
    sequence s_restore;
        write_timing [*8];
    endsequence
    chk_cycle_shape: assert property (cycle_start && !busy |=> s_read ##1 s_restore)
        else $error("read phase not followed by write phase");
    chk_clear_first: assert property (cycle_start && !busy |=> !data_latch_clear_n)
        else $error("latch clear missing at cycle start");
    chk_sel_onehot: assert property (read_timing || write_timing |->
        $onehot(~x_driver_sel_n) && $onehot(~y_driver_sel_n)) else $error("select not one-hot");
    chk_sel_idle: assert property (!read_timing && !write_timing |->
        &x_driver_sel_n && &y_driver_sel_n) else $error("select outside timing");
    chk_phase_excl: assert property (!(read_timing && write_timing))
        else $error("read and write timing overlap");
    chk_strobe_window: assert property (sense_strobe_even_half || sense_strobe_odd_half |->
        read_timing && !(sense_strobe_even_half && sense_strobe_odd_half)) else $error("bad strobe");
    chk_half_pick: assert property (sense_strobe_even_half && !interleave_four_way |->
        !word_address[13]) else $error("wrong half strobed");
    chk_half_odd: assert property (sense_strobe_odd_half && !interleave_four_way |->
        word_address[13]) else $error("wrong odd half strobed");
    chk_sense_set: assert property (sense_strobe_even_half && sense_even_pulse |=>
        memory_data_latch) else $error("sensed one not latched");
    chk_inhibit_zero: assert property (inhibit_select_even_half |->
        inhibit_even_on == !memory_data_latch) else $error("inhibit driver wrong");
    chk_bus_drive: assert property (!bus_drive_enable_n && memory_data_latch |->
        !bus_data_oe_n) else $error("set bit not driven on bus");
endmodule // cmbd_datapath_properties

// ===== cmbd_requester.sv
// Requester and core stack model for one data bit
module cmbd_requester (
    input wire mclk,
    input wire write_request,
    input wire busy,
    input wire wdata,
    input wire read_timing,
    input wire write_timing,
    input wire sense_strobe_even_half,
    input wire sense_strobe_odd_half,
    input wire inhibit_select_even_half,
    input wire inhibit_select_odd_half,
    input wire inhibit_even_on,
    input wire inhibit_odd_on,
    input wire bus_data_out,
    input wire bus_data_oe_n,
    output wire sense_even_pulse,
    output wire sense_odd_pulse,
    output wire bus_data_in_n,
    output reg rd_bit = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    reg [1:0] core = 2'h0;
    // Released line is pulled up, reading as zero
    wire line = bus_data_oe_n ? 1'b1 : bus_data_out;
    assign bus_data_in_n = (busy && write_request) ? !wdata : 1'b1;
    assign sense_even_pulse = read_timing && core[0];
    assign sense_odd_pulse = read_timing && core[1];
    always @(posedge mclk) begin
        // Destructive read leaves the sensed core at zero
        if (read_timing && sense_strobe_even_half)
            core[0] <= 1'b0;
        if (read_timing && sense_strobe_odd_half)
            core[1] <= 1'b0;
        if (write_timing && inhibit_select_even_half)
            core[0] <= !inhibit_even_on;
        if (write_timing && inhibit_select_odd_half)
            core[1] <= !inhibit_odd_on;
        if (!busy)
            rd_bit <= 1'b0;
        else if (!line)
            rd_bit <= 1'b1;
    end
endmodule // cmbd_requester

// ===== cmbd_datapath_bench.sv
// Self-checking bench for the core memory bit data path
module cmbd_datapath_bench;
    timeunit 1ns;
    timeprecision 1ns;
    reg mclk = 1'b0, rst_n = 1'b0, cycle_start = 1'b0, write_request = 1'b0, fw = 1'b0;
    reg wdata = 1'b0;
    reg [20:0] lo = 21'h0;
    reg [14:0] wa = 15'h0;
    reg [1:0] msize = 2'h0;
    reg [55:0] sel;
    reg [5:0] hit;
    wire sep, sop, din_n, busy, done, rt, wt, se, so, ise, iso, ie, io, clr_n, ld, bde_n, bdo;
    wire oe_n, lat, rd_bit;
    wire [15:0] xd, xs, ys;
    wire [7:0] yd;
    integer errors = 0, total_checks = 0;
    always #25 mclk = ~mclk;
    cmbd_datapath i_cmbd_datapath (.mclk(mclk), .rst_n(rst_n), .cycle_start(cycle_start),
        .write_request(write_request), .bus_address_lo(lo), .word_address(wa),
        .interleave_four_way(fw), .memory_size(msize), .sense_even_pulse(sep),
        .sense_odd_pulse(sop), .bus_data_in_n(din_n), .busy(busy), .cycle_done(done),
        .x_driver_sel_n(xd), .x_switch_sel_n(xs), .y_driver_sel_n(yd), .y_switch_sel_n(ys),
        .read_timing(rt), .write_timing(wt), .sense_strobe_even_half(se),
        .sense_strobe_odd_half(so), .inhibit_select_even_half(ise),
        .inhibit_select_odd_half(iso), .inhibit_even_on(ie), .inhibit_odd_on(io),
        .data_latch_clear_n(clr_n), .data_latch_load_clock(ld), .bus_drive_enable_n(bde_n),
        .bus_data_out(bdo), .bus_data_oe_n(oe_n), .memory_data_latch(lat));
    cmbd_requester i_cmbd_requester (.mclk(mclk), .write_request(write_request), .busy(busy),
        .wdata(wdata), .read_timing(rt), .write_timing(wt), .sense_strobe_even_half(se),
        .sense_strobe_odd_half(so), .inhibit_select_even_half(ise),
        .inhibit_select_odd_half(iso), .inhibit_even_on(ie), .inhibit_odd_on(io),
        .bus_data_out(bdo), .bus_data_oe_n(oe_n), .sense_even_pulse(sep),
        .sense_odd_pulse(sop), .bus_data_in_n(din_n), .rd_bit(rd_bit));
    task check(input string name, input [15:0] seen, input [15:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("BAD %0s expected %h seen %h", name, exp, seen);
        end
    endtask
    task run(input w, input [14:0] a, input [20:0] l, input f, input [1:0] m, input d);
        integer n;
        @(posedge mclk);
        write_request <= w;
        wa <= a;
        lo <= l;
        fw <= f;
        msize <= m;
        wdata <= d;
        cycle_start <= 1'b1;
        @(posedge mclk);
        cycle_start <= 1'b0;
        hit = 6'h00;
        for (n = 0; n < 40 && done !== 1'b1; n = n + 1) begin
            @(posedge mclk);
            #1;
            if (rt)
                sel = {xd, xs, yd, ys};
            hit = hit | {ld, se, so, ie & wt, io & wt, lat & wt};
        end
        check("cycle done", done, 1'b1);
        check("idle after done", busy, 1'b0);
    endtask
    task t_select;
        reg [14:0] a;
        integer i;
        for (i = 0; i < 4; i = i + 1) begin
            a = (i == 0) ? 15'h0000 : (i == 1) ? 15'h7fff : 15'h2d69 << i;
            run(1'b0, a, 21'h0, 1'b0, 2'h0, 1'b0);
            check("x drivers", sel[55:40], ~(16'h1 << a[3:0]));
            check("x switches", sel[39:24], ~(16'h1 << a[7:4]));
            check("y drivers", {8'h0, sel[23:16]}, {8'h0, ~(8'h1 << a[10:8])});
            check("y switches", sel[15:0], ~(16'h1 << a[14:11]));
        end
        $display("test select done");
    endtask
    task t_data;
        run(1'b1, 15'h0123, 21'h0, 1'b0, 2'h0, 1'b1);
        check("write one latch", hit[0], 1'b1);
        check("write one inhibit", hit[2:1], 2'h0);
        check("write load clock", hit[5], 1'b1);
        check("write no bus drive", rd_bit, 1'b0);
        run(1'b1, 15'h2123, 21'h0, 1'b0, 2'h0, 1'b0);
        check("write zero latch", hit[0], 1'b0);
        check("write zero inhibit", hit[2:1], 2'h1);
        run(1'b0, 15'h0123, 21'h0, 1'b0, 2'h0, 1'b0);
        check("read one bus", rd_bit, 1'b1);
        check("even strobe", hit[4:3], 2'h2);
        check("read no load clock", hit[5], 1'b0);
        run(1'b0, 15'h2123, 21'h0, 1'b0, 2'h0, 1'b0);
        check("read zero bus", rd_bit, 1'b0);
        check("odd strobe", hit[4:3], 2'h1);
        run(1'b0, 15'h0123, 21'h0, 1'b0, 2'h0, 1'b0);
        check("restored one", rd_bit, 1'b1);
        $display("test data done");
    endtask
    task t_swap;
        integer i;
        for (i = 0; i < 4; i = i + 1) begin
            run(1'b0, 15'h0000, 21'h1 << (19 - ((i < 3) ? i : 2)), 1'b1, i[1:0], 1'b0);
            check("swap bit one", hit[4:3], 2'h1);
            run(1'b0, 15'h2000, 21'h0, 1'b1, i[1:0], 1'b0);
            check("swap bit zero", hit[4:3], 2'h2);
        end
        run(1'b0, 15'h0000, 21'h80000, 1'b0, 2'h0, 1'b0);
        check("swap ignored", hit[4:3], 2'h2);
        $display("test swap done");
    endtask
    task results;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #(2400 * 50);
        errors = errors + 1;
        results;
    end
    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        t_select;
        t_data;
        t_swap;
        results;
    end
endmodule // cmbd_datapath_bench
bind cmbd_datapath cmbd_datapath_properties i_chk (.mclk(mclk), .rst_n(rst_n),
    .cycle_start(cycle_start), .busy(busy), .word_address(word_address),
    .interleave_four_way(interleave_four_way), .sense_even_pulse(sense_even_pulse),
    .x_driver_sel_n(x_driver_sel_n), .y_driver_sel_n(y_driver_sel_n),
    .read_timing(read_timing), .write_timing(write_timing),
    .sense_strobe_even_half(sense_strobe_even_half),
    .sense_strobe_odd_half(sense_strobe_odd_half),
    .inhibit_select_even_half(inhibit_select_even_half), .inhibit_even_on(inhibit_even_on),
    .data_latch_clear_n(data_latch_clear_n), .bus_drive_enable_n(bus_drive_enable_n),
    .bus_data_oe_n(bus_data_oe_n), .memory_data_latch(memory_data_latch));
